// ===== src/cs_core.sv
// Processor state, primary memory and instruction field decoder with AXI4-Lite access.
`timescale 1ns/1ps
// Summary of operation
// - Even word access returns word at bits 15:1.
// - Odd word access: returns zero, boundary flag.
// - Even byte access returns low byte.
// - Odd byte access returns high byte.
// - Memory is 16-bit words, 2**k deep.
// - Eight 16-bit general registers.
// - Register 6 is stack pointer, 7 program counter.
// - Status word upper byte unused.
// - Status bits 7:5 hold priority.
// - Status bit 4 is the trace flag.
// - Status bits 3:0 are N, Z, V, C.
// - Stack access below octal 400 flags overflow.
// - Nonexistent memory reference sets time-out flag.
// - Reserved instruction sets illegal-instruction flag.
// - Activity is run 0, wait 1, off 2.
// - Keep power-up flag; power-low bit follows the synchronized pin.
// - Exactly one decode class per instruction.
// - Opcode 15:12, source field 11:6 split.
// - Destination field 5:0, mode and register.
// - Unary opcode from bits 15:6.
// - Opcode 0001 selects word copy.
// - Fetch at program counter, then add 2.
// - Trace set: trap via vector 14, clear trace.
module cs_core #(
   parameter int MEM_K = cs_pkg::CS_MEM_K
) (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   // Power supply sense pin.
   input  wire logic                         powerLowIn,
   // AXI4-Lite write address and data.
   input  wire logic [cs_pkg::CS_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [cs_pkg::CS_AXI_AW-1:0] s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // Processor state.
   output cs_pkg::cs_activity_type           activityState,
   output cs_pkg::cs_fields_type             instrFields,
   output cs_pkg::cs_class_type              instrClass
);
   localparam int IW = (MEM_K < 15) ? MEM_K : 15;

   function automatic cs_pkg::cs_class_type classify(input logic [15:0] i);
      if (i[15:12] == cs_pkg::CS_OP_WORD_COPY) return cs_pkg::CL_COPY;
      if (i[14:12] != 3'h0 && i[14:12] != 3'h7) return cs_pkg::CL_BINARY;
      if (i[15:12] == 4'hf) return cs_pkg::CL_FLOAT;
      if (i[15:12] == 4'h7) return cs_pkg::CL_EXTENDED;
      if (i[15:9] == 7'h04) return cs_pkg::CL_JSR;
      if (i[15:9] == 7'h44) return cs_pkg::CL_TRAP;
      if (i[14:11] == 4'h1) return cs_pkg::CL_UNARY;
      if (i[14:11] == 4'h0 && (i[15] || i[10:8] != 3'h0)) return cs_pkg::CL_BRANCH;
      return cs_pkg::CL_RESERVED;
   endfunction

   function automatic cs_pkg::cs_fields_type unpack(input logic [15:0] i);
      cs_pkg::cs_fields_type f;
      f.opcode         = i[15:12];
      f.sourceMode     = i[11:9];
      f.sourceRegister = i[8:6];
      f.destMode       = i[5:3];
      f.destRegister   = i[2:0];
      f.unaryOp        = i[15:6];
      f.jsrOp          = i[15:9];
      f.branchOp       = i[15:8];
      f.branchOffset   = {{8{i[7]}}, i[7:0]};
      f.extOp          = i[15:9];
      f.extRegister    = i[8:6];
      f.floatOp        = i[15:8];
      f.floatRegister  = i[7:6];
      return f;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
      return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // State.
   logic [15:0]               physicalMemory [0:(1<<IW)-1];
   logic [15:0]               gpr_r [0:7];
   logic [7:0]                ps_r;
   logic [cs_pkg::CS_FLG_W-1:0] flags_r;
   logic [cs_pkg::CS_FLG_W-1:0] flagSet;
   logic [cs_pkg::CS_FLG_W-1:0] flagClr;
   logic [16:0]               memAddr_r;
   logic [15:0]               instrWord_r;
   logic                      bootPending_r;
   logic                      powerSync1_r;
   logic                      powerSync2_r;
   cs_pkg::cs_state_type      state_r;
   cs_pkg::cs_state_type      stateNxt;
   cs_pkg::cs_activity_type   activityNxt;

   // Bus slave state.
   logic                      awHeld_r;
   logic                      wHeld_r;
   logic [cs_pkg::CS_AXI_AW-1:0] awAddr_r;
   logic [31:0]               wData_r;
   logic [3:0]                wStrb_r;

   // Processor datapath controls.
   logic                      cpuGprWe;
   logic [2:0]                cpuGprIdx;
   logic [15:0]               cpuGprData;
   logic                      cpuMemWe;
   logic [15:0]               cpuAddr;
   logic [15:0]               cpuMemData;
   logic                      cpuPsWe;
   logic [7:0]                cpuPsData;
   logic [cs_pkg::CS_FLG_W-1:0] cpuFlagSet;
   logic                      goOff;
   logic                      loadInstr;

   wire [15:0] pc      = gpr_r[cs_pkg::CS_PC_INDEX];
   wire [15:0] sp      = gpr_r[cs_pkg::CS_SP_INDEX];
   wire [15:0] spDown  = sp - cs_pkg::CS_WORD_BYTES;
   wire        trace   = ps_r[cs_pkg::CS_PS_TRACE];
   wire [15:0] cpuWord = physicalMemory[cpuAddr[IW:1]];
   wire        cpuNone = (({1'b0, cpuAddr[15:1]} >> MEM_K) != 16'h0000);
   wire        cpuOdd  = cpuAddr[0];
   wire [15:0] srcVal  = gpr_r[instrFields.sourceRegister];

   // Software memory window.
   wire [15:0] swAddr     = memAddr_r[15:0];
   wire        swByte     = memAddr_r[cs_pkg::CS_MEMADDR_BYTE];
   wire [15:0] swWord     = physicalMemory[swAddr[IW:1]];
   wire        swNone     = (({1'b0, swAddr[15:1]} >> MEM_K) != 16'h0000);
   wire        swBoundary = ~swByte & swAddr[0];
   wire [15:0] swByteVal  = swAddr[0] ? {8'h00, swWord[15:8]} : {8'h00, swWord[7:0]};
   wire [15:0] swReadVal  = (swBoundary | swNone) ? 16'h0000 : (swByte ? swByteVal : swWord);
   wire [15:0] swByteWr   = swAddr[0] ? {wData_r[7:0], swWord[7:0]}
                                      : {swWord[15:8], wData_r[7:0]};
   wire [15:0] swWordWr   = swByte ? swByteWr : merge16(swWord, wData_r[15:0], wStrb_r[1:0]);

   // Bus handshakes and decode.
   wire awTake = s_axi_awvalid & s_axi_awready;
   wire wTake  = s_axi_wvalid & s_axi_wready;
   wire wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
   wire arTake = s_axi_arvalid & s_axi_arready;
   wire awHeldNxt = awTake | (awHeld_r & ~wrFire);
   wire wHeldNxt  = wTake | (wHeld_r & ~wrFire);
   wire rValidNxt = arTake | (s_axi_rvalid & ~s_axi_rready);

   wire wrCtrl  = wrFire & (awAddr_r == cs_pkg::CS_OFF_CONTROL);
   wire wrFlags = wrFire & (awAddr_r == cs_pkg::CS_OFF_FLAGS);
   wire wrPsw   = wrFire & (awAddr_r == cs_pkg::CS_OFF_PSW);
   wire wrMemA  = wrFire & (awAddr_r == cs_pkg::CS_OFF_MEMADDR);
   wire wrMemD  = wrFire & (awAddr_r == cs_pkg::CS_OFF_MEMDATA);
   wire wrGpr   = wrFire & (awAddr_r[7:5] == cs_pkg::CS_GPR_BASE_HI) & (awAddr_r[1:0] == 2'h0);
   wire wrMapped = wrCtrl | wrFlags | wrPsw | wrMemA | wrMemD | wrGpr
                   | (awAddr_r == cs_pkg::CS_OFF_INSTR) | (awAddr_r == cs_pkg::CS_OFF_DECODE);
   wire swMemWe = wrMemD & ~swBoundary & ~swNone & (swByte ? wStrb_r[0] : 1'b1);

   wire [7:0] ra    = s_axi_araddr;
   wire rdGpr   = (ra[7:5] == cs_pkg::CS_GPR_BASE_HI) & (ra[1:0] == 2'h0);
   wire rdMemD  = ra == cs_pkg::CS_OFF_MEMDATA;
   wire rdHit   = rdGpr | rdMemD | (ra == cs_pkg::CS_OFF_CONTROL) | (ra == cs_pkg::CS_OFF_FLAGS)
                  | (ra == cs_pkg::CS_OFF_PSW) | (ra == cs_pkg::CS_OFF_INSTR)
                  | (ra == cs_pkg::CS_OFF_DECODE) | (ra == cs_pkg::CS_OFF_MEMADDR);
   wire [31:0] rdVal =
      rdGpr ? {16'h0000, gpr_r[ra[4:2]]} :
      rdMemD ? {16'h0000, swReadVal} :
      (ra == cs_pkg::CS_OFF_CONTROL) ? {30'h0, activityState} :
      (ra == cs_pkg::CS_OFF_FLAGS) ? {26'h0, powerSync2_r, flags_r} :
      (ra == cs_pkg::CS_OFF_PSW) ? {24'h0, ps_r} :
      (ra == cs_pkg::CS_OFF_INSTR) ? {16'h0000, instrWord_r} :
      (ra == cs_pkg::CS_OFF_DECODE) ? {28'h0, instrClass} :
      (ra == cs_pkg::CS_OFF_MEMADDR) ? {15'h0, memAddr_r} : 32'h0;

   // Flag events from processor faults, software window accesses and power-up.
   wire swAccess = wrMemD | (arTake & rdMemD);
   assign flagSet = cpuFlagSet
                  | ({{(cs_pkg::CS_FLG_W-1){1'b0}}, swAccess & swBoundary}
                     << cs_pkg::CS_FLG_BOUNDARY)
                  | ({{(cs_pkg::CS_FLG_W-1){1'b0}}, swAccess & swNone} << cs_pkg::CS_FLG_TIMEOUT)
                  | ({{(cs_pkg::CS_FLG_W-1){1'b0}}, bootPending_r} << cs_pkg::CS_FLG_POWERUP);
   assign flagClr = wrFlags ? wData_r[cs_pkg::CS_FLG_W-1:0] : '0;

   // Instruction interpretation sequence.
   always_comb begin
      stateNxt   = state_r;
      cpuGprWe   = 1'b0;
      cpuGprIdx  = cs_pkg::CS_PC_INDEX;
      cpuGprData = 16'h0000;
      cpuMemWe   = 1'b0;
      cpuAddr    = pc;
      cpuMemData = 16'h0000;
      cpuPsWe    = 1'b0;
      cpuPsData  = ps_r;
      cpuFlagSet = '0;
      goOff      = 1'b0;
      loadInstr  = 1'b0;
      unique case (state_r)
         cs_pkg::ST_FETCH: begin
            if (activityState == cs_pkg::CS_RUN) begin
               if (cpuOdd) begin
                  cpuFlagSet[cs_pkg::CS_FLG_BOUNDARY] = 1'b1;
                  goOff = 1'b1;
               end else if (cpuNone) begin
                  cpuFlagSet[cs_pkg::CS_FLG_TIMEOUT] = 1'b1;
                  goOff = 1'b1;
               end else begin
                  loadInstr  = 1'b1;
                  cpuGprWe   = 1'b1;
                  cpuGprData = pc + cs_pkg::CS_WORD_BYTES;
                  stateNxt   = cs_pkg::ST_EXEC;
               end
            end
         end
         cs_pkg::ST_EXEC: begin
            stateNxt = cs_pkg::ST_FETCH;
            if (instrClass == cs_pkg::CL_RESERVED) begin
               cpuFlagSet[cs_pkg::CS_FLG_ILLEGAL] = 1'b1;
               goOff = 1'b1;
            end else begin
               if (instrClass == cs_pkg::CL_COPY && instrFields.sourceMode == 3'h0
                   && instrFields.destMode == 3'h0) begin
                  cpuGprWe   = 1'b1;
                  cpuGprIdx  = instrFields.destRegister;
                  cpuGprData = srcVal;
                  cpuPsWe    = 1'b1;
                  cpuPsData[cs_pkg::CS_PS_N] = srcVal[15];
                  cpuPsData[cs_pkg::CS_PS_Z] = (srcVal == 16'h0000);
                  cpuPsData[cs_pkg::CS_PS_V] = 1'b0;
               end
               if (trace) begin
                  stateNxt = cs_pkg::ST_PUSH_PS;
               end
            end
         end
         cs_pkg::ST_PUSH_PS, cs_pkg::ST_PUSH_PC: begin
            cpuAddr = spDown;
            if (cpuOdd | cpuNone) begin
               cpuFlagSet[cs_pkg::CS_FLG_BOUNDARY] = cpuOdd;
               cpuFlagSet[cs_pkg::CS_FLG_TIMEOUT]  = cpuNone & ~cpuOdd;
               goOff    = 1'b1;
               stateNxt = cs_pkg::ST_FETCH;
            end else begin
               cpuMemWe   = 1'b1;
               cpuMemData = (state_r == cs_pkg::ST_PUSH_PS) ? {8'h00, ps_r} : pc;
               cpuGprWe   = 1'b1;
               cpuGprIdx  = cs_pkg::CS_SP_INDEX;
               cpuGprData = spDown;
               cpuFlagSet[cs_pkg::CS_FLG_STACK] = spDown < cs_pkg::CS_STACK_LIMIT;
               stateNxt = (state_r == cs_pkg::ST_PUSH_PS) ? cs_pkg::ST_PUSH_PC
                                                          : cs_pkg::ST_VEC_PC;
            end
         end
         cs_pkg::ST_VEC_PC: begin
            cpuAddr    = cs_pkg::CS_TRACE_VECTOR;
            cpuGprWe   = 1'b1;
            cpuGprData = cpuWord;
            stateNxt   = cs_pkg::ST_VEC_PS;
         end
         cs_pkg::ST_VEC_PS: begin
            cpuAddr   = cs_pkg::CS_TRACE_VECTOR + cs_pkg::CS_WORD_BYTES;
            cpuPsWe   = 1'b1;
            cpuPsData = cpuWord[7:0];
            cpuPsData[cs_pkg::CS_PS_TRACE] = 1'b0;
            stateNxt  = cs_pkg::ST_FETCH;
         end
      endcase
   end

   assign activityNxt = goOff ? cs_pkg::CS_OFF :
                        (wrCtrl && wData_r[1:0] != 2'h3) ? cs_pkg::cs_activity_type'(wData_r[1:0])
                                                         : activityState;

   // General registers, processor writes win over software writes.
   generate
      for (genvar g = 0; g < 8; g++) begin : gen_gpr
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               gpr_r[g] <= cs_pkg::CS_GPR_RESET;
            end else if (cpuGprWe && cpuGprIdx == 3'(g)) begin
               gpr_r[g] <= cpuGprData;
            end else if (wrGpr && awAddr_r[4:2] == 3'(g)) begin
               gpr_r[g] <= merge16(gpr_r[g], wData_r[15:0], wStrb_r[1:0]);
            end
         end
      end
   endgenerate

   // Primary memory has no reset; processor writes win over software writes.
   always_ff @(posedge clk) begin
      if (cpuMemWe) begin
         physicalMemory[cpuAddr[IW:1]] <= cpuMemData;
      end else if (swMemWe) begin
         physicalMemory[swAddr[IW:1]] <= swWordWr;
      end
   end

   // Processor state and flags.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r       <= cs_pkg::ST_FETCH;
         activityState <= cs_pkg::CS_OFF;
         ps_r          <= cs_pkg::CS_PS_RESET;
         flags_r       <= '0;
         bootPending_r <= 1'b1;
         powerSync1_r  <= 1'b0;
         powerSync2_r  <= 1'b0;
         memAddr_r     <= '0;
         instrWord_r   <= 16'h0000;
         instrFields   <= '0;
         instrClass    <= cs_pkg::CL_RESERVED;
      end else begin
         state_r       <= stateNxt;
         activityState <= activityNxt;
         bootPending_r <= 1'b0;
         powerSync1_r  <= powerLowIn;
         powerSync2_r  <= powerSync1_r;
         flags_r       <= (flags_r & ~flagClr) | flagSet;
         if (cpuPsWe) begin
            ps_r <= cpuPsData;
         end else if (wrPsw) begin
            ps_r <= wStrb_r[0] ? wData_r[7:0] : ps_r;
         end
         if (wrMemA) begin
            memAddr_r <= {wData_r[cs_pkg::CS_MEMADDR_BYTE], wData_r[15:0]};
         end
         if (loadInstr) begin
            instrWord_r <= cpuWord;
            instrFields <= unpack(cpuWord);
            instrClass  <= classify(cpuWord);
         end
      end
   end

   // AXI4-Lite slave.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= '0;
         wData_r       <= 32'h0;
         wStrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= cs_pkg::CS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= cs_pkg::CS_RESP_OKAY;
      end else begin
         awHeld_r      <= awHeldNxt;
         wHeld_r       <= wHeldNxt;
         s_axi_awready <= ~awHeldNxt;
         s_axi_wready  <= ~wHeldNxt;
         if (awTake) begin
            awAddr_r <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (wTake) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? cs_pkg::CS_RESP_OKAY : cs_pkg::CS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_rvalid  <= rValidNxt;
         s_axi_arready <= ~rValidNxt;
         if (arTake) begin
            s_axi_rdata <= rdHit ? rdVal : 32'h0;
            s_axi_rresp <= rdHit ? cs_pkg::CS_RESP_OKAY : cs_pkg::CS_RESP_SLVERR;
         end
      end
   end
endmodule // cs_core

// ===== src/cs_pkg.sv
// Shared constants, types and register map for the processor state block.
package cs_pkg;
   // Register map, byte addresses on the AXI4-Lite port.
   localparam int         CS_AXI_AW       = 8;
   localparam logic [7:0] CS_OFF_CONTROL  = 8'h00;
   localparam logic [7:0] CS_OFF_FLAGS    = 8'h04;
   localparam logic [7:0] CS_OFF_PSW      = 8'h08;
   localparam logic [7:0] CS_OFF_INSTR    = 8'h0c;
   localparam logic [7:0] CS_OFF_DECODE   = 8'h10;
   localparam logic [7:0] CS_OFF_MEMADDR  = 8'h14;
   localparam logic [7:0] CS_OFF_MEMDATA  = 8'h18;
   localparam logic [2:0] CS_GPR_BASE_HI  = 3'h1;
   // Memory size and flag positions.
   localparam int         CS_MEM_K        = 12;
   localparam int         CS_FLG_BOUNDARY = 0;
   localparam int         CS_FLG_STACK    = 1;
   localparam int         CS_FLG_TIMEOUT  = 2;
   localparam int         CS_FLG_ILLEGAL  = 3;
   localparam int         CS_FLG_POWERUP  = 4;
   localparam int         CS_FLG_POWERLOW = 5;
   localparam int         CS_FLG_W        = 5;
   localparam int         CS_MEMADDR_BYTE = 16;
   // Processor state word fields.
   localparam int         CS_PS_TRACE     = 4;
   localparam int         CS_PS_N         = 3;
   localparam int         CS_PS_Z         = 2;
   localparam int         CS_PS_V         = 1;
   localparam int         CS_PS_C         = 0;
   // Reset values and fixed addresses.
   localparam logic [7:0]  CS_PS_RESET     = 8'h00;
   localparam logic [15:0] CS_GPR_RESET    = 16'h0000;
   localparam logic [15:0] CS_WORD_BYTES   = 16'h0002;
   localparam logic [15:0] CS_TRACE_VECTOR = 16'h000c;
   localparam logic [15:0] CS_STACK_LIMIT  = 16'h0100;
   localparam logic [2:0]  CS_SP_INDEX     = 3'h6;
   localparam logic [2:0]  CS_PC_INDEX     = 3'h7;
   localparam logic [3:0]  CS_OP_WORD_COPY = 4'h1;
   localparam logic [1:0]  CS_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  CS_RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {CS_RUN, CS_WAIT, CS_OFF} cs_activity_type;

   typedef enum logic [3:0] {
      CL_COPY, CL_BINARY, CL_FLOAT, CL_EXTENDED, CL_JSR, CL_TRAP, CL_UNARY, CL_BRANCH, CL_RESERVED
   } cs_class_type;

   typedef enum {ST_FETCH, ST_EXEC, ST_PUSH_PS, ST_PUSH_PC, ST_VEC_PC, ST_VEC_PS} cs_state_type;

   typedef struct packed {
      logic [3:0]  opcode;
      logic [2:0]  sourceMode;
      logic [2:0]  sourceRegister;
      logic [2:0]  destMode;
      logic [2:0]  destRegister;
      logic [9:0]  unaryOp;
      logic [6:0]  jsrOp;
      logic [7:0]  branchOp;
      logic [15:0] branchOffset;
      logic [6:0]  extOp;
      logic [2:0]  extRegister;
      logic [7:0]  floatOp;
      logic [1:0]  floatRegister;
   } cs_fields_type;
endpackage

// ===== test/cs_core_properties.sv
// Port assertions for the processor state block.
`timescale 1ns/1ps
module cs_core_properties (
   // Clock and reset.
   input wire logic                    clk,
   input wire logic                    reset_n,
   // Bus handshakes.
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   // Processor state.
   input wire cs_pkg::cs_activity_type activityState,
   input wire cs_pkg::cs_fields_type   instrFields,
   input wire cs_pkg::cs_class_type    instrClass
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WRITE_ANSWER: assert property (s_wr_both |=> ##1 s_axi_bvalid)
      else $error("Write response late.");
   AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped.");
   AST_READ_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("Read data late.");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped.");
   AST_READ_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Read address open while data pending.");
   AST_ACT_CODE: assert property (activityState != 2'h3)
      else $error("Activity outside three states.");
   AST_OFF_FROZEN: assert property (activityState == cs_pkg::CS_OFF
      |=> $stable(instrFields))
      else $error("Fields changed while off.");
   AST_COPY_OPCODE: assert property (instrClass == cs_pkg::CL_COPY
      |-> instrFields.opcode == cs_pkg::CS_OP_WORD_COPY)
      else $error("Copy class with other opcode.");
   AST_BRANCH_SIGN: assert property (instrClass == cs_pkg::CL_BRANCH
      |-> instrFields.branchOffset[15:8] == {8{instrFields.branchOffset[7]}})
      else $error("Branch offset not sign extended.");
endmodule // cs_core_properties

// ===== test/cs_supply_model.sv
// Supply monitor model that drives the power-low sense pin.
`timescale 1ns/1ps
module cs_supply_model (
   // Clock and request.
   input  wire logic clk,
   input  wire logic lowReq,
   // Sense pin.
   output logic      powerLowIn
);
   always_ff @(posedge clk) begin
      powerLowIn <= lowReq;
   end
endmodule // cs_supply_model

// ===== test/testbench.sv
// Self-checking bench for the processor state block.
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] CTL = cs_pkg::CS_OFF_CONTROL, FLG = cs_pkg::CS_OFF_FLAGS;
   localparam logic [7:0] PSW = cs_pkg::CS_OFF_PSW, MA = cs_pkg::CS_OFF_MEMADDR;
   localparam logic [7:0] MD = cs_pkg::CS_OFF_MEMDATA;
   logic                    clk, reset_n, lowReq, powerLowIn;
   logic [7:0]              s_axi_awaddr, s_axi_araddr;
   logic [31:0]             s_axi_wdata, s_axi_rdata, got;
   logic [3:0]              s_axi_wstrb;
   logic [1:0]              s_axi_bresp, s_axi_rresp, resp;
   logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                    s_axi_rvalid, s_axi_rready;
   cs_pkg::cs_activity_type activityState;
   cs_pkg::cs_fields_type   instrFields;
   cs_pkg::cs_class_type    instrClass;
   int                      errors, comparisons, n;
   assign s_axi_wstrb = 4'hf;
   always #5 clk = ~clk;
   cs_supply_model i_supply (.clk, .lowReq, .powerLowIn);
   cs_core #(.MEM_K(6)) i_dut (.clk, .reset_n, .powerLowIn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .activityState, .instrFields, .instrClass);
   task automatic stop_test();
      if (errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      errors++;
      $display("[FAIL] %0t no answer", $time);
      stop_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b0;
      t = 0;
      do begin
         @(posedge clk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
         if (++t > 40) tmo();
      end while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      t = 0;
      do begin
         @(posedge clk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
         if (++t > 40) tmo();
      end while (!(s_axi_rvalid && s_axi_rready));
      got = s_axi_rdata;
      resp = s_axi_rresp;
      chk(got, e);
   endtask
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      errors = 0;
      comparisons = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, lowReq} = '0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rc(CTL, 32'h2);
      rc(FLG, 32'h10);
      rc(8'h1c, 32'h0);
      chk(32'(resp), 32'(cs_pkg::CS_RESP_SLVERR));
      wr(8'h1c, 32'h5);
      chk(32'(resp), 32'(cs_pkg::CS_RESP_SLVERR));
      wr(CTL, 32'h3);
      rc(CTL, 32'h2);
      wr(CTL, 32'h1);
      rc(CTL, 32'h1);
      wr(FLG, 32'h3f);
      rc(FLG, 32'h0);
      lowReq <= 1'b1;
      repeat (5) @(posedge clk);
      rc(FLG, 32'h20);
      lowReq <= 1'b0;
      wr(PSW, 32'hffff);
      chk(32'(resp), 32'(cs_pkg::CS_RESP_OKAY));
      rc(PSW, 32'hff);
      for (n = 0; n < 8; n++) wr(8'h20 + 8'(4 * n), 32'h0101 * n);
      for (n = 0; n < 8; n++) rc(8'h20 + 8'(4 * n), 32'h0101 * n);
      wr(MA, 32'h0);
      wr(MD, 32'h1042);
      wr(MA, 32'h2);
      wr(MD, 32'h10c7);
      wr(MA, 32'h10005);
      wr(MD, 32'hcd);
      rc(MD, 32'hcd);
      wr(MA, 32'h10004);
      wr(MD, 32'hab);
      rc(MD, 32'hab);
      wr(MA, 32'h4);
      rc(MD, 32'hcdab);
      wr(MA, 32'h5);
      rc(MD, 32'h0);
      rc(FLG, 32'h1);
      wr(MA, 32'h80);
      rc(MD, 32'h0);
      rc(FLG, 32'h5);
      wr(FLG, 32'h3f);
      wr(8'h24, 32'h8000);
      wr(8'h2c, 32'h1);
      wr(8'h3c, 32'h0);
      wr(PSW, 32'h3);
      wr(CTL, 32'h0);
      for (n = 0; activityState !== cs_pkg::CS_OFF; n++) begin
         @(posedge clk);
         if (n > 60) tmo();
      end
      rc(8'h28, 32'h8000);
      rc(8'h3c, 32'h1);
      rc(PSW, 32'h1);
      rc(FLG, 32'h1);
      rc(cs_pkg::CS_OFF_INSTR, 32'h10c7);
      rc(cs_pkg::CS_OFF_DECODE, 32'h0);
      chk({16'h0, instrFields.opcode, instrFields.sourceMode, instrFields.sourceRegister,
           instrFields.destMode, instrFields.destRegister}, 32'h10c7);
      chk({22'h0, instrFields.unaryOp}, 32'h43);
      chk({16'h0, instrFields.branchOffset}, 32'hffc7);
      chk(32'(instrClass), 32'(cs_pkg::CL_COPY));
      rc(CTL, 32'h2);
      wr(MA, 32'hc);
      wr(MD, 32'hc);
      wr(MA, 32'he);
      wr(MD, 32'hf0);
      wr(8'h38, 32'h40);
      wr(8'h3c, 32'h0);
      wr(FLG, 32'h3f);
      wr(PSW, 32'h10);
      wr(CTL, 32'h0);
      for (n = 0; activityState !== cs_pkg::CS_OFF; n++) begin
         @(posedge clk);
         if (n > 60) tmo();
      end
      rc(8'h3c, 32'he);
      rc(8'h38, 32'h3c);
      rc(PSW, 32'he0);
      rc(FLG, 32'ha);
      rc(cs_pkg::CS_OFF_DECODE, 32'h8);
      wr(MA, 32'h3e);
      rc(MD, 32'h18);
      stop_test();
   end
endmodule // testbench
bind cs_core cs_core_properties i_props (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .activityState,
   .instrFields, .instrClass);
